// ---- core/rcrs_core.sv ----
/*
   Register set of a load-store core with an operand-format datapath,
   reached over a classic Wishbone slave. Writing a 16-bit instruction
   to the command register while no multiply is in flight executes it against the register set.
   Assumes software supplies memory data in the memory-data register.
*/
`timescale 1ns/10ps
`default_nettype none
module rcrs_core #(
   // Stack pointer and program counter held in the reset vector.
   parameter logic [31:0] VEC_PC = 32'h0000_0100,
   parameter logic [31:0] VEC_SP = 32'h0000_0020
) (
   // Clock and synchronous reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave request and response.
   input wire rcrs_pkg::rcrs_wbreq_type wb_i,
   output var rcrs_pkg::rcrs_wbrsp_type wb_o,
   // Core status.
   output logic busy_o,
   output logic addr_err_o,
   output logic t_flag_o
);
   // ----------------------------------------------------------------
   // State and next values.
   // ----------------------------------------------------------------
   // General registers and the small hardware stack memory.
   logic [31:0] gpr_reg [16];
   logic [31:0] gpr_next [16];
   logic [31:0] stk_reg [rcrs_pkg::STK_WORDS];
   logic [31:0] stk_next [rcrs_pkg::STK_WORDS];
   // Control and system registers.
   logic [31:0] sr_reg, sr_next, gbr_reg, gbr_next, vbr_reg, vbr_next;
   logic [31:0] mac_high_reg, mac_high_next, mac_low_reg, mac_low_next;
   logic [31:0] pr_reg, pr_next, pc_reg, pc_next;
   // Memory data, effective address and delayed branch target.
   logic [31:0] mdat_reg, mdat_next, eadr_reg, eadr_next;
   logic [31:0] tgt_reg, tgt_next;
   logic pend_reg, pend_next, aerr_reg, aerr_next, busy_reg, busy_next;
   // Multiplier result in flight.
   logic [63:0] mres_reg, mres_next;
   logic [1:0] mkind_reg, mkind_next;
   logic [2:0] cnt_reg, cnt_next;
   rcrs_pkg::rcrs_state_type state_reg, state_next;
   rcrs_pkg::rcrs_wbrsp_type rsp_reg, rsp_next;
   // ----------------------------------------------------------------
   // Decode helpers.
   // ----------------------------------------------------------------
   logic hit, wr, ex, w1c, aerr_set, ldo, mis;
   logic [7:0] wa, imm, mbyte;
   logic [31:0] bm, rdval, wdat, sx, zx, ea, ldv, tgt, pc_seq, ra, rb;
   logic [15:0] ins;
   logic [3:0] op, rn, rm;
   logic [1:0] lg, lsz, mk;
   logic [2:0] si;
   logic take;
   logic signed [31:0] p16;
   logic signed [63:0] p32;
   logic [63:0] mac;

   assign wb_o = rsp_reg;
   assign busy_o = busy_reg;
   assign addr_err_o = aerr_reg;
   assign t_flag_o = sr_reg[rcrs_pkg::SR_T];

   // ----------------------------------------------------------------
   // Next-state logic.
   // ----------------------------------------------------------------
   // Bus slave, instruction execution and multiplier sequencing.
   always_comb
   begin
      gpr_next = gpr_reg;
      stk_next = stk_reg;
      sr_next = sr_reg;
      gbr_next = gbr_reg;
      vbr_next = vbr_reg;
      mac_high_next = mac_high_reg;
      mac_low_next = mac_low_reg;
      pr_next = pr_reg;
      pc_next = pc_reg;
      mdat_next = mdat_reg;
      eadr_next = eadr_reg;
      tgt_next = tgt_reg;
      pend_next = pend_reg;
      mres_next = mres_reg;
      mkind_next = mkind_reg;
      cnt_next = cnt_reg;
      state_next = state_reg;
      w1c = 1'b0;
      aerr_set = 1'b0;
      ldo = 1'b0;
      ea = 32'h0000_0000;
      lsz = 2'h2;
      take = 1'b0;
      // A request is answered in the cycle after it appears.
      hit = wb_i.cyc && wb_i.stb;
      wr = hit && wb_i.we && rsp_reg.ack;
      wa = {wb_i.adr[7:2], 2'b00};
      bm = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}}, {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
      // Read mux; unmapped words read as zero.
      rdval = 32'h0000_0000;
      if (wa[7:6] == 2'b00)
         rdval = gpr_reg[wa[5:2]]; // [RULE_01]
      else
         case (wa)
            rcrs_pkg::ADR_SR: rdval = sr_reg;
            rcrs_pkg::ADR_GBR: rdval = gbr_reg;
            rcrs_pkg::ADR_VBR: rdval = vbr_reg;
            rcrs_pkg::ADR_MAC_HIGH: rdval = mac_high_reg;
            rcrs_pkg::ADR_MAC_LOW: rdval = mac_low_reg;
            rcrs_pkg::ADR_PR: rdval = pr_reg;
            rcrs_pkg::ADR_PC: rdval = pc_reg;
            rcrs_pkg::ADR_MDAT: rdval = mdat_reg;
            rcrs_pkg::ADR_EADR: rdval = eadr_reg;
            rcrs_pkg::ADR_STAT: rdval = {28'h0, pend_reg, t_flag_o, aerr_reg, busy_reg};
            default: rdval = 32'h0000_0000;
         endcase
      rsp_next.ack = hit && !rsp_reg.ack;
      rsp_next.dat = rsp_next.ack ? rdval : rsp_reg.dat;
      // Byte lanes merge new data into the old word.
      wdat = (rdval & ~bm) | (wb_i.dat & bm);
      // The write lands at the edge where the master sees ack.
      if (wr)
      begin
         if (wa[7:6] == 2'b00)
            gpr_next[wa[5:2]] = wdat;
         else
            case (wa)
               rcrs_pkg::ADR_SR: sr_next = wdat & rcrs_pkg::SR_WMASK;
               rcrs_pkg::ADR_GBR: gbr_next = wdat;
               rcrs_pkg::ADR_VBR: vbr_next = wdat;
               rcrs_pkg::ADR_MAC_HIGH: mac_high_next = wdat;
               rcrs_pkg::ADR_MAC_LOW: mac_low_next = wdat;
               rcrs_pkg::ADR_PR: pr_next = wdat;
               rcrs_pkg::ADR_PC: pc_next = wdat;
               rcrs_pkg::ADR_MDAT: mdat_next = wdat;
               rcrs_pkg::ADR_STAT: w1c = wb_i.dat[rcrs_pkg::ST_AERR] && wb_i.sel[0];
               default: w1c = 1'b0;
            endcase
      end
      // Instruction fields of the 16-bit word.
      ins = wdat[15:0]; // [RULE_14]
      op = ins[15:12];
      rn = ins[11:8];
      rm = ins[7:4];
      imm = ins[7:0];
      lg = ins[9:8];
      mk = ins[9:8];
      ra = gpr_reg[rn];
      rb = gpr_reg[rm];
      sx = {{24{imm[7]}}, imm};
      zx = {24'h0, imm};
      tgt = pc_reg + 32'd4 + {sx[30:0], 1'b0};
      si = gpr_reg[15][4:2];
      mac = {mac_high_reg, mac_low_reg};
      p16 = $signed(ra[15:0]) * $signed(rb[15:0]);
      p32 = $signed(ra) * $signed(rb);
      // A pending delayed branch takes effect after its slot.
      pc_seq = pend_reg ? tgt_reg : pc_reg + 32'd2; // [RULE_21]
      // The multiplier finishes its result; commands written meanwhile are not executed.
      ex = 1'b0;
      case (state_reg)
         rcrs_pkg::S_RUN:
            ex = wr && (wa == rcrs_pkg::ADR_CMD); // [RULE_15]
         rcrs_pkg::S_MUL:
         begin
            cnt_next = cnt_reg - 3'd1;
            if (cnt_reg == 3'd1)
            begin
               state_next = rcrs_pkg::S_RUN;
               mac_low_next = mres_reg[31:0]; // [RULE_06]
               if (mkind_reg != rcrs_pkg::MK_MUL16)
                  mac_high_next = mres_reg[63:32];
            end
         end
         default: state_next = rcrs_pkg::S_RUN;
      endcase
      // Execute one instruction in the cycle it is written.
      if (ex)
      begin
         pc_next = pc_seq;
         pend_next = 1'b0;
         case (op)
            rcrs_pkg::OP_MOVI:
               gpr_next[rn] = sx; // [RULE_11]
            rcrs_pkg::OP_ADDI:
               gpr_next[rn] = ra + sx; // [RULE_11] [RULE_20]
            rcrs_pkg::OP_CMPEQI:
               sr_next[rcrs_pkg::SR_T] = gpr_reg[0] == sx; // [RULE_02] [RULE_11]
            rcrs_pkg::OP_LOGI:
               case (lg)
                  rcrs_pkg::LG_TST: sr_next[rcrs_pkg::SR_T] = (gpr_reg[0] & zx) == 32'h0; // [RULE_12]
                  rcrs_pkg::LG_AND: gpr_next[0] = gpr_reg[0] & zx; // [RULE_12]
                  rcrs_pkg::LG_OR: gpr_next[0] = gpr_reg[0] | zx;
                  default: gpr_next[0] = gpr_reg[0] ^ zx;
               endcase
            rcrs_pkg::OP_CMPGE:
               sr_next[rcrs_pkg::SR_T] = $signed(ra) >= $signed(rb); // [RULE_20]
            rcrs_pkg::OP_CMPEQ:
               sr_next[rcrs_pkg::SR_T] = ra == rb; // [RULE_20]
            rcrs_pkg::OP_ADD:
               gpr_next[rn] = ra + rb; // [RULE_16]
            rcrs_pkg::OP_LOAD:
            begin
               ldo = 1'b1;
               lsz = ins[3:2];
               case (ins[1:0])
                  rcrs_pkg::AM_IDX: ea = rb + gpr_reg[0]; // [RULE_02]
                  rcrs_pkg::AM_GBR: ea = gbr_reg + gpr_reg[0]; // [RULE_04]
                  default: ea = rb;
               endcase
            end
            rcrs_pkg::OP_MOVPCW:
            begin
               ldo = 1'b1;
               lsz = rcrs_pkg::SZ_W;
               ea = pc_reg + 32'd4 + {23'h0, imm, 1'b0}; // [RULE_13]
            end
            rcrs_pkg::OP_MOVPCL:
            begin
               ldo = 1'b1;
               ea = (pc_reg & 32'hFFFF_FFFC) + 32'd4 + {22'h0, imm, 2'b00}; // [RULE_13]
            end
            rcrs_pkg::OP_BRA:
            begin
               pend_next = 1'b1; // [RULE_17]
               tgt_next = tgt;
               if (ins[8])
                  pr_next = pc_reg + 32'd4; // [RULE_06]
            end
            rcrs_pkg::OP_BCOND:
            begin
               take = ins[8] ? t_flag_o : !t_flag_o; // [RULE_19]
               if (take && ins[9])
               begin
                  pend_next = 1'b1; // [RULE_17]
                  tgt_next = tgt;
               end
               else if (take)
                  pc_next = tgt;
            end
            rcrs_pkg::OP_MUL:
            begin
               state_next = rcrs_pkg::S_MUL;
               mkind_next = mk;
               case (mk)
                  rcrs_pkg::MK_MUL16:
                  begin
                     mres_next = {32'h0, p16};
                     cnt_next = rcrs_pkg::MUL16_CYC - 3'd1; // [RULE_18]
                  end
                  rcrs_pkg::MK_MAC16:
                  begin
                     mres_next = mac + {{32{p16[31]}}, p16};
                     cnt_next = rcrs_pkg::MAC16_CYC - 3'd1; // [RULE_18]
                  end
                  rcrs_pkg::MK_MUL32:
                  begin
                     mres_next = p32;
                     cnt_next = rcrs_pkg::MUL32_CYC - 3'd1; // [RULE_18]
                  end
                  default:
                  begin
                     mres_next = mac + p32;
                     cnt_next = rcrs_pkg::MUL32_CYC - 3'd1;
                  end
               endcase
            end
            rcrs_pkg::OP_ANDM:
            begin
               eadr_next = gbr_reg + gpr_reg[0];
               mdat_next = mdat_reg & zx; // [RULE_16]
            end
            rcrs_pkg::OP_EXC:
            begin
               if (gpr_reg[15][1:0] != 2'b00)
                  aerr_set = 1'b1; // [RULE_10]
               else if (imm[7])
               begin
                  pc_next = stk_reg[si]; // [RULE_03]
                  sr_next = stk_reg[si + 3'd1] & rcrs_pkg::SR_WMASK;
                  gpr_next[15] = gpr_reg[15] + 32'd8;
               end
               else
               begin
                  stk_next[si - 3'd1] = sr_reg; // [RULE_03]
                  stk_next[si - 3'd2] = pc_reg + 32'd2;
                  gpr_next[15] = gpr_reg[15] - 32'd8;
                  pc_next = vbr_reg + {24'h0, imm[5:0], 2'b00}; // [RULE_05]
               end
            end
            default: pc_next = pc_seq;
         endcase
      end
      // Loads extend the memory operand and check its alignment.
      case (lsz)
         rcrs_pkg::SZ_B: ldv = {{24{mdat_reg[7]}}, mdat_reg[7:0]}; // [RULE_08]
         rcrs_pkg::SZ_W: ldv = {{16{mdat_reg[15]}}, mdat_reg[15:0]}; // [RULE_08]
         default: ldv = mdat_reg;
      endcase
      mis = (lsz == rcrs_pkg::SZ_W) ? ea[0] : (lsz != rcrs_pkg::SZ_B) && (ea[1:0] != 2'b00);
      if (ldo)
      begin
         eadr_next = ea;
         if (mis)
            aerr_set = 1'b1; // [RULE_09]
         else
            gpr_next[rn] = ldv;
      end
      // A new error wins over a clear in the same cycle.
      aerr_next = aerr_set || (aerr_reg && !w1c);
      busy_next = state_next == rcrs_pkg::S_MUL;
   end

   // ----------------------------------------------------------------
   // Registers.
   // ----------------------------------------------------------------
   // Reset loads the vector contents and the documented values.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 15; i++)
            gpr_reg[i] <= 32'h0000_0000;
         for (int i = 0; i < rcrs_pkg::STK_WORDS; i++)
            stk_reg[i] <= 32'h0000_0000;
         gpr_reg[15] <= VEC_SP; // [RULE_07]
         pc_reg <= VEC_PC;
         sr_reg <= rcrs_pkg::SR_RESET;
         vbr_reg <= rcrs_pkg::VBR_RESET;
         gbr_reg <= 32'h0000_0000;
         mac_high_reg <= 32'h0000_0000;
         mac_low_reg <= 32'h0000_0000;
         pr_reg <= 32'h0000_0000;
         mdat_reg <= 32'h0000_0000;
         eadr_reg <= 32'h0000_0000;
         tgt_reg <= 32'h0000_0000;
         pend_reg <= 1'b0;
         aerr_reg <= 1'b0;
         busy_reg <= 1'b0;
         mres_reg <= 64'h0;
         mkind_reg <= 2'h0;
         cnt_reg <= 3'h0;
         state_reg <= rcrs_pkg::S_RUN;
         rsp_reg <= '0;
      end
      else
      begin
         gpr_reg <= gpr_next;
         stk_reg <= stk_next;
         pc_reg <= pc_next;
         sr_reg <= sr_next;
         vbr_reg <= vbr_next;
         gbr_reg <= gbr_next;
         mac_high_reg <= mac_high_next;
         mac_low_reg <= mac_low_next;
         pr_reg <= pr_next;
         mdat_reg <= mdat_next;
         eadr_reg <= eadr_next;
         tgt_reg <= tgt_next;
         pend_reg <= pend_next;
         aerr_reg <= aerr_next;
         busy_reg <= busy_next;
         mres_reg <= mres_next;
         mkind_reg <= mkind_next;
         cnt_reg <= cnt_next;
         state_reg <= state_next;
         rsp_reg <= rsp_next;
      end
   end

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   assign mbyte = mdat_reg[7:0];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Delayed branch: slot runs sequentially with the branch pending.
   sequence s_bra_issued;
      ex && op == rcrs_pkg::OP_BRA;
   endsequence
   sequence s_slot_open;
      pend_reg && pc_reg == $past(pc_reg) + 32'd2;
   endsequence
   // Long multiply keeps the core busy for three more cycles.
   sequence s_mul_run;
      busy_o [*3] ##1 !busy_o;
   endsequence

   a_reset_load: assert property ($past(rst_i) |-> pc_reg == VEC_PC // [RULE_07]
      && gpr_reg[15] == VEC_SP && vbr_reg == 32'h0 && sr_reg == rcrs_pkg::SR_RESET)
      else $error("reset values wrong");
   a_imm_sext: assert property (ex && op == rcrs_pkg::OP_MOVI |=> // [RULE_11]
      $signed(gpr_reg[$past(rn)]) == $signed($past(imm)))
      else $error("move immediate not sign-extended");
   a_and_upper: assert property (ex && op == rcrs_pkg::OP_LOGI // [RULE_12]
      && lg == rcrs_pkg::LG_AND |=> gpr_reg[0][31:8] == 24'h0)
      else $error("and immediate left upper bits");
   a_word_align: assert property (ex && op == rcrs_pkg::OP_LOAD // [RULE_09]
      && lsz == rcrs_pkg::SZ_W && ea[0] |=> aerr_reg)
      else $error("odd word load gave no error");
   a_byte_sext: assert property (ex && op == rcrs_pkg::OP_LOAD // [RULE_08]
      && lsz == rcrs_pkg::SZ_B |=> $signed(gpr_reg[$past(rn)]) == $signed($past(mbyte)))
      else $error("byte load not sign-extended");
   a_add_keeps_t: assert property (ex && op == rcrs_pkg::OP_ADDI |=> $stable(t_flag_o)) // [RULE_20]
      else $error("add changed the flag");
   a_cmpge_flag: assert property (ex && op == rcrs_pkg::OP_CMPGE |=> // [RULE_20]
      t_flag_o == ($signed($past(ra)) >= $signed($past(rb))))
      else $error("greater-or-equal flag wrong");
   a_bt_taken: assert property (ex && op == rcrs_pkg::OP_BCOND && !ins[9] && ins[8] // [RULE_19]
      && t_flag_o |=> pc_reg == $past(tgt))
      else $error("branch if true not taken");
   a_delay_slot: assert property (s_bra_issued |=> s_slot_open) // [RULE_17]
      else $error("branch not delayed");
   a_mul_latency: assert property (ex && op == rcrs_pkg::OP_MUL // [RULE_18]
      && mk == rcrs_pkg::MK_MUL32 |=> s_mul_run)
      else $error("long multiply latency wrong");
   a_stack_push: assert property (ex && op == rcrs_pkg::OP_EXC && !imm[7] // [RULE_03]
      && gpr_reg[15][1:0] == 2'b00 |=> gpr_reg[15] == $past(gpr_reg[15]) - 32'd8)
      else $error("exception entry stack wrong");
endmodule
`default_nettype wire

// ---- core/rcrs_pkg.sv ----
/*
   Shared definitions of the register set block: register map, status
   fields, opcodes, access sizes, multiplier latencies and bus carriers.
   Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
// Functional notes
// [RULE_01] Sixteen general, three control, four system registers.
// [RULE_02] Register zero is index and fixed operand.
// [RULE_03] Stack pointer saves and restores status, program counter.
// [RULE_04] Global base addresses peripheral register accesses.
// [RULE_05] Vector base anchors the exception vector area.
// [RULE_06] Multiply results, return address, program address held.
// [RULE_07] Reset loads vectors, clears vector base, masks set.
// [RULE_08] Byte and word loads sign-extend to longword.
// [RULE_09] Misaligned word or longword raises address error.
// [RULE_10] Stack accessed only as aligned longwords.
// [RULE_11] Move, add, compare-equal immediates sign-extend.
// [RULE_12] Test and logic immediates zero-extend.
// [RULE_13] Wide immediates fetched program-counter relative.
// [RULE_14] Every instruction is sixteen bits.
// [RULE_15] Basic instructions complete in one cycle.
// [RULE_16] Arithmetic on registers, bit logic on memory.
// [RULE_17] Unconditional branch delayed; conditional both forms.
// [RULE_18] Multiplier latencies of two to four cycles.
// [RULE_19] Conditional branches test the true flag.
// [RULE_20] Compares set the flag; add leaves it.
// [RULE_21] Sequential execution advances by two bytes.
package rcrs_pkg;
   // -------------------------------------------------------------
   // Register map, byte addresses.
   // -------------------------------------------------------------
   localparam logic [7:0] ADR_GPR = 8'h00;
   localparam logic [7:0] ADR_SR = 8'h40;
   localparam logic [7:0] ADR_GBR = 8'h44;
   localparam logic [7:0] ADR_VBR = 8'h48;
   localparam logic [7:0] ADR_MAC_HIGH = 8'h4C;
   localparam logic [7:0] ADR_MAC_LOW = 8'h50;
   localparam logic [7:0] ADR_PR = 8'h54;
   localparam logic [7:0] ADR_PC = 8'h58;
   localparam logic [7:0] ADR_CMD = 8'h5C;
   localparam logic [7:0] ADR_MDAT = 8'h60;
   localparam logic [7:0] ADR_STAT = 8'h64;
   localparam logic [7:0] ADR_EADR = 8'h68;
   // -------------------------------------------------------------
   // Status register fields and reset values.
   // -------------------------------------------------------------
   localparam int SR_T = 0;
   localparam logic [31:0] SR_WMASK = 32'h0000_03F3;
   localparam logic [31:0] SR_RESET = 32'h0000_00F0;
   localparam logic [31:0] VBR_RESET = 32'h0000_0000;
   localparam int ST_BUSY = 0;
   localparam int ST_AERR = 1;
   // -------------------------------------------------------------
   // Opcodes in bits 15:12 of the instruction word.
   // -------------------------------------------------------------
   localparam logic [3:0] OP_MOVI = 4'h1;
   localparam logic [3:0] OP_ADDI = 4'h2;
   localparam logic [3:0] OP_CMPEQI = 4'h3;
   localparam logic [3:0] OP_LOGI = 4'h4;
   localparam logic [3:0] OP_CMPGE = 4'h5;
   localparam logic [3:0] OP_CMPEQ = 4'h6;
   localparam logic [3:0] OP_ADD = 4'h7;
   localparam logic [3:0] OP_LOAD = 4'h8;
   localparam logic [3:0] OP_MOVPCW = 4'h9;
   localparam logic [3:0] OP_MOVPCL = 4'hA;
   localparam logic [3:0] OP_BRA = 4'hB;
   localparam logic [3:0] OP_BCOND = 4'hC;
   localparam logic [3:0] OP_MUL = 4'hD;
   localparam logic [3:0] OP_ANDM = 4'hE;
   localparam logic [3:0] OP_EXC = 4'hF;
   // Logic sub-ops, access sizes, load address modes, multiply kinds.
   localparam logic [1:0] LG_TST = 2'h0;
   localparam logic [1:0] LG_AND = 2'h1;
   localparam logic [1:0] LG_OR = 2'h2;
   localparam logic [1:0] SZ_B = 2'h0;
   localparam logic [1:0] SZ_W = 2'h1;
   localparam logic [1:0] AM_IDX = 2'h1;
   localparam logic [1:0] AM_GBR = 2'h2;
   localparam logic [1:0] MK_MUL16 = 2'h0;
   localparam logic [1:0] MK_MAC16 = 2'h1;
   localparam logic [1:0] MK_MUL32 = 2'h2;
   // -------------------------------------------------------------
   // Multiplier latencies in cycles and stack size.
   // -------------------------------------------------------------
   localparam logic [2:0] MUL16_CYC = 3'h2;
   localparam logic [2:0] MAC16_CYC = 3'h3;
   localparam logic [2:0] MUL32_CYC = 3'h4;
   localparam int STK_WORDS = 8;
   // Sequencer states and bus carriers.
   typedef enum logic {S_RUN, S_MUL} rcrs_state_type;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } rcrs_wbreq_type;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } rcrs_wbrsp_type;
endpackage

// ---- dv/tb.sv ----
/*
   Testbench of the register set: Wishbone tasks and instruction runs.
   Assumes rcrs_pkg and rcrs_core with their default vectors.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
   // ------------------------------------------------------------
   // Signals and counters.
   // ------------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   rcrs_pkg::rcrs_wbreq_type wb_i = '0;
   rcrs_pkg::rcrs_wbrsp_type wb_o;
   logic busy_o;
   logic addr_err_o;
   logic t_flag_o;
   int errors = 0;
   int compares = 0;
   logic [31:0] v;
   logic [31:0] p;
   rcrs_core rcrs_core_i (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
      .busy_o(busy_o), .addr_err_o(addr_err_o), .t_flag_o(t_flag_o));
   // The clock toggles every half period of 50 ns.
   initial
   begin
      forever #50 clk_i = ~clk_i;
   end
   // Compares a seen value with its expectation.
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // One classic cycle, held until ack is sampled high at an edge.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_i <= {1'b1, 1'b1, w, a, 4'hF, d};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_o.ack !== 1'b1 && n < 20);
      if (n >= 20)
         errors++;
      v = wb_o.dat;
      wb_i <= '0;
   endtask
   // Reads a register and compares it.
   task rd(input logic [7:0] a, input logic [31:0] e, input string n);
      bus(1'b0, a, 32'h0);
      chk(n, e, v);
   endtask
   // Executes one instruction; lets its edge land before returning.
   task ex(input logic [15:0] c);
      bus(1'b1, rcrs_pkg::ADR_CMD, {16'h0, c});
      #1;
   endtask
   // Prints the counts and the verdict, then stops.
   task end_sim;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(rcrs_pkg::ADR_PC, 32'h0000_0100, "pc");
      rd(8'h3C, 32'h0000_0020, "sp");
      rd(rcrs_pkg::ADR_VBR, 32'h0, "vbr");
      rd(rcrs_pkg::ADR_SR, 32'h0000_00F0, "sr");
      rd(8'h7C, 32'h0, "unmapped");
      // Every general register keeps a full 32-bit pattern.
      for (int i = 0; i < 16; i++)
         bus(1'b1, 8'(i * 4), 32'(~i));
      for (int i = 0; i < 16; i++)
         rd(8'(i * 4), 32'(~i), "gpr");
      ex(16'h1180);
      rd(8'h04, 32'hFFFF_FF80, "movi");
      rd(rcrs_pkg::ADR_PC, 32'h0000_0102, "pc step");
      ex(16'h1000);
      ex(16'h3000);
      ex(16'h2101);
      chk("t add", 32'h1, {31'h0, t_flag_o});
      rd(8'h04, 32'hFFFF_FF81, "addi");
      ex(16'h10FF);
      ex(16'h41F0);
      rd(8'h00, 32'h0000_00F0, "and");
      ex(16'h1205);
      ex(16'h1307);
      ex(16'h5230);
      chk("t ge0", 32'h0, {31'h0, t_flag_o});
      ex(16'h5320);
      chk("t ge1", 32'h1, {31'h0, t_flag_o});
      // Loads sign-extend and reject misaligned words.
      bus(1'b1, rcrs_pkg::ADR_MDAT, 32'h0000_8080);
      ex(16'h1504);
      ex(16'h8451);
      rd(8'h10, 32'hFFFF_FF80, "ldb");
      ex(16'h8454);
      rd(8'h10, 32'hFFFF_8080, "ldw");
      ex(16'h1501);
      ex(16'h8454);
      chk("aerr", 32'h1, {31'h0, addr_err_o});
      bus(1'b1, rcrs_pkg::ADR_STAT, 32'h2);
      rd(rcrs_pkg::ADR_STAT, 32'h4, "stat clear");
      // Bit logic works on the memory operand at global base plus index.
      ex(16'hE0F0);
      rd(rcrs_pkg::ADR_MDAT, 32'h80, "andm");
      rd(rcrs_pkg::ADR_EADR, 32'hF0, "andm ea");
      ex(16'h9401);
      rd(8'h10, 32'h80, "movpcw");
      // The slot after a branch runs before the jump.
      bus(1'b0, rcrs_pkg::ADR_PC, 32'h0);
      p = v;
      ex(16'hB102);
      ex(16'h1605);
      rd(rcrs_pkg::ADR_PC, p + 32'h8, "branch");
      rd(8'h18, 32'h5, "slot");
      rd(rcrs_pkg::ADR_PR, p + 32'h4, "return address");
      // Ordinary conditional branches test the true flag, still set.
      bus(1'b0, rcrs_pkg::ADR_PC, 32'h0);
      p = v;
      ex(16'hC102);
      rd(rcrs_pkg::ADR_PC, p + 32'h8, "bt");
      ex(16'hC002);
      rd(rcrs_pkg::ADR_PC, p + 32'hA, "bf");
      // A long multiply holds busy for three cycles after its issue edge.
      ex(16'h1603);
      ex(16'h1804);
      ex(16'hD680);
      chk("busy", 32'h1, {31'h0, busy_o});
      repeat (3) @(posedge clk_i);
      chk("busy last", 32'h1, {31'h0, busy_o});
      @(posedge clk_i);
      chk("busy end", 32'h0, {31'h0, busy_o});
      rd(rcrs_pkg::ADR_MAC_LOW, 32'hC, "mul");
      rd(rcrs_pkg::ADR_MAC_HIGH, 32'h0, "mul high");
      // Exception entry and return go through the stack.
      bus(1'b1, rcrs_pkg::ADR_VBR, 32'h0000_0200);
      bus(1'b1, 8'h3C, 32'h0000_0020);
      bus(1'b0, rcrs_pkg::ADR_PC, 32'h0);
      p = v;
      ex(16'hF001);
      rd(rcrs_pkg::ADR_PC, 32'h0000_0204, "vector");
      rd(8'h3C, 32'h0000_0018, "sp entry");
      ex(16'hF080);
      rd(rcrs_pkg::ADR_PC, p + 32'h2, "return");
      rd(8'h3C, 32'h0000_0020, "sp return");
      end_sim();
   end
   // A hang is cut short well beyond the expected run.
   initial
   begin
      repeat (3000) @(posedge clk_i);
      errors++;
      end_sim();
   end
endmodule
`default_nettype wire
